// *** core/ekq_pkg.sv ***
// keypad scan event queue: shared constants, register map and state type
// assumes a 10 MHz clock and a register port fed by an external serial slave
// How it works
// - rows and columns joined by three select registers
// - key code is row times ten plus column plus one
// - idle drives matrix columns low, rows pulled high
// - any selected row low in idle starts scan
// - press logged after closure lasting one period
// - logged event sets key flag when enabled, except an overwrite in a full queue
// - two successive closed samples 25 ms apart
// - keep sampling every 25 ms while keys held
// - release logged after two open samples
// - all released returns scanner to idle
// - ten event registers share one queue
// - event counter counts logged events up to ten
// - bit 7 press status, low seven bits code
// - each event register read pops the event
// - empty queue reads return zero
// - reset leaves no line in the matrix
// - counter decrements as events are read
// - full queue plus new event sets overflow flag
// - overflow discards or overwrites oldest by mode
// - key flag clear refused while events remain
package ekq_pkg;

	// matrix and queue geometry
	localparam int NUM_COLS   = 10;
	localparam int NUM_ROWS   = 8;
	localparam int NUM_KEYS   = NUM_COLS * NUM_ROWS;
	localparam int FIFO_DEPTH = 10;

	// timing: scan period and column settle time
	localparam int CLK_HZ          = 10_000_000;
	localparam int SCAN_PERIOD_MS  = 25;
	localparam int SCAN_CYC        = (CLK_HZ / 1000) * SCAN_PERIOD_MS;
	localparam int COL_SETTLE_CYC  = 6;

	// register offsets
	localparam logic [7:0] ADDR_CFG        = 8'h01;
	localparam logic [7:0] ADDR_INT_STAT   = 8'h02;
	localparam logic [7:0] ADDR_EVT_CNT    = 8'h03;
	localparam logic [7:0] ADDR_EVT_FIRST  = 8'h04;
	localparam logic [7:0] ADDR_EVT_LAST   = 8'h0D;
	localparam logic [7:0] ADDR_SEL_ROW    = 8'h1D;
	localparam logic [7:0] ADDR_SEL_COL_LO = 8'h1E;
	localparam logic [7:0] ADDR_SEL_COL_HI = 8'h1F;

	// field positions
	localparam int CFG_KEY_EVENT_IRQ_ENABLE_BIT  = 0;
	localparam int CFG_OVF_IEN_BIT = 1;
	localparam int CFG_WRAP_BIT    = 5;
	localparam int STAT_KE_BIT     = 0;
	localparam int STAT_OVF_BIT    = 1;
	localparam int EVT_STATUS_BIT  = 7;

	// reset values
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] SEL_RST = 8'h00;

	typedef enum logic [2:0] {
		EKQ_IDLE,
		EKQ_DRIVE,
		EKQ_EMIT,
		EKQ_CHECK,
		EKQ_WAIT
	} ekq_state_t;

endpackage : ekq_pkg

// *** core/ekq_sync.sv ***
// three-stage input synchroniser with agreement filter for pin inputs
// assumes inputs are asynchronous to clk; output updates when stages 2 and 3 agree
`timescale 1ns/1ps
module ekq_sync #(
	parameter int              W       = 8,
	parameter logic [W-1:0]    RST_VAL = '1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// pins and filtered result
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] filt_out
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] filt_r;

	// per-bit agreement between the later stages
	wire [W-1:0] agree = ~(s2_r ^ s3_r);
	wire [W-1:0] filt_nxt = (agree & s3_r) | (~agree & filt_r);

	// stage 1 feeds only stage 2
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r   <= RST_VAL;
			s2_r   <= RST_VAL;
			s3_r   <= RST_VAL;
			filt_r <= RST_VAL;
		end else begin
			s1_r   <= pin_in;
			s2_r   <= s1_r;
			s3_r   <= s2_r;
			filt_r <= filt_nxt;
		end
	end

	assign filt_out = filt_r;

endmodule : ekq_sync

// *** core/ekq_skid.sv ***
// two-entry buffer between the scanner and the event queue
// assumes same-clock producer and consumer; a stalled consumer stalls the producer
`timescale 1ns/1ps
module ekq_skid #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// filling side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// draining side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);

	logic [W-1:0] mem_r [2];
	logic         wp_r;
	logic         rp_r;
	logic [1:0]   cnt_r;

	// honest full and empty from the occupancy count
	wire push = in_valid & in_ready;
	wire pop  = out_valid & out_ready;
	assign in_ready  = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_data  = mem_r[rp_r];

	// storage has no reset; only pointers and count do
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end

	// pointers and count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r  <= 1'b0;
			rp_r  <= 1'b0;
			cnt_r <= 2'h0;
		end else begin
			if (push) wp_r <= ~wp_r;
			if (pop) rp_r <= ~rp_r;
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end

endmodule : ekq_skid

// *** core/ekq_keypad.sv ***
// keypad matrix scanner with debounced press/release events and a ten-entry queue
// assumes a parallel register port driven by an external serial slave, open-drain pins
`timescale 1ns/1ps
module ekq_keypad
	import ekq_pkg::*;
#(
	parameter int SCAN_PERIOD_CYC = ekq_pkg::SCAN_CYC
) (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	// register port
	input  wire logic [7:0]                 reg_addr,
	input  wire logic                       reg_wr,
	input  wire logic [7:0]                 reg_wdata,
	input  wire logic                       reg_rd,
	output logic      [7:0]                 reg_rdata,
	// matrix rows (inputs with pull-up)
	input  wire logic [ekq_pkg::NUM_ROWS-1:0] row_in,
	output logic      [ekq_pkg::NUM_ROWS-1:0] row_pullup_en,
	// matrix columns (open drain)
	output logic      [ekq_pkg::NUM_COLS-1:0] col_out,
	output logic      [ekq_pkg::NUM_COLS-1:0] col_oe,
	output logic      [ekq_pkg::NUM_COLS-1:0] col_pullup_en,
	// host interrupt (open drain, active low)
	output logic                            int_out,
	output logic                            int_oe
);

	import ekq_pkg::*;

	localparam int TW = $clog2(SCAN_PERIOD_CYC);

	// register file
	logic [7:0]          cfg_r;
	logic [NUM_ROWS-1:0] row_sel_r;
	logic [NUM_COLS-1:0] col_sel_r;
	logic                ke_flag_r;
	logic                ovf_flag_r;
	logic [7:0]          rdata_r;

	// scanner
	ekq_state_t          state_r;
	logic [3:0]          col_r;
	logic [2:0]          settle_r;
	logic [6:0]          key_r;
	logic [TW-1:0]       timer_r;
	logic [NUM_KEYS-1:0] cur_r;
	logic [NUM_KEYS-1:0] prev_r;
	logic [NUM_KEYS-1:0] held_r;
	logic [NUM_KEYS-1:0] cur_nxt;

	// event queue
	logic [7:0]          fifo_r [FIFO_DEPTH];
	logic [3:0]          wp_r;
	logic [3:0]          rp_r;
	logic [3:0]          cnt_r;

	// address decode used by read data and pop
	function automatic logic is_evt_addr(input logic [7:0] a);
		is_evt_addr = (a >= ADDR_EVT_FIRST) && (a <= ADDR_EVT_LAST);
	endfunction : is_evt_addr

	function automatic logic [3:0] ptr_inc(input logic [3:0] p);
		ptr_inc = (p == 4'(FIFO_DEPTH - 1)) ? 4'h0 : p + 4'h1;
	endfunction : ptr_inc

	// row pins pass the synchroniser; idle level is high
	logic [NUM_ROWS-1:0] row_f;
	ekq_sync #(
		.W       (NUM_ROWS),
		.RST_VAL ({NUM_ROWS{1'b1}})
	) u_row_sync (
		.clk      (clk),
		.rst_n    (rst_n),
		.pin_in   (row_in),
		.filt_out (row_f)
	);

	// closed rows are low rows that belong to the matrix
	wire [NUM_ROWS-1:0] row_closed = ~row_f & row_sel_r;
	wire                any_row    = |row_closed;

	// per-key debounce decisions at the key being emitted
	wire key_press = cur_r[key_r] & prev_r[key_r] & ~held_r[key_r];
	wire key_rel   = ~cur_r[key_r] & ~prev_r[key_r] & held_r[key_r];
	wire key_evt   = key_press | key_rel;

	// buffer between the scanner and the queue
	wire       sk_in_valid = (state_r == EKQ_EMIT) & key_evt;
	wire       sk_in_ready;
	wire       sk_out_valid;
	wire [7:0] sk_out_data;
	wire [7:0] evt_byte = {key_press, key_r + 7'h01};
	wire       evt_rd   = reg_rd & is_evt_addr(reg_addr);
	// the queue refuses a push in a pop cycle, keeping pointer updates simple
	wire       q_ready  = ~evt_rd;

	ekq_skid #(
		.W (8)
	) u_skid (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (sk_in_valid),
		.in_ready  (sk_in_ready),
		.in_data   (evt_byte),
		.out_valid (sk_out_valid),
		.out_ready (q_ready),
		.out_data  (sk_out_data)
	);

	// queue status and overflow handling
	wire q_push  = sk_out_valid & q_ready;
	wire q_full  = (cnt_r == 4'(FIFO_DEPTH));
	wire q_empty = (cnt_r == 4'h0);
	wire q_pop   = evt_rd & ~q_empty;
	wire wrap_en = cfg_r[CFG_WRAP_BIT];
	wire q_write = q_push & (~q_full | wrap_en);
	wire q_ovf   = q_push & q_full;

	// timebase only runs outside idle
	wire tick = (timer_r == TW'(SCAN_PERIOD_CYC - 1));

	// one column's closed rows folded into the sample image; a skipped column
	// reads open, since the synchronised rows still show the last driven column
	always_comb begin
		cur_nxt = cur_r;
		for (int r = 0; r < NUM_ROWS; r++) begin
			for (int c = 0; c < NUM_COLS; c++) begin
				if (c == int'(col_r)) begin
					cur_nxt[r * NUM_COLS + c] = row_closed[r] & col_sel_r[c];
				end
			end
		end
	end

	// column drive: idle holds all matrix columns low, scan one at a time
	wire [NUM_COLS-1:0] col_onehot = NUM_COLS'(1) << col_r;
	wire                scanning   = (state_r == EKQ_DRIVE);
	assign col_out       = '0;
	assign col_oe        = scanning ? (col_sel_r & col_onehot) : col_sel_r;
	assign row_pullup_en = {NUM_ROWS{1'b1}};
	assign col_pullup_en = ~col_sel_r;

	// scanner state machine
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r  <= EKQ_IDLE;
			col_r    <= 4'h0;
			settle_r <= 3'h0;
			key_r    <= 7'h00;
			cur_r    <= '0;
			prev_r   <= '0;
			held_r   <= '0;
		end else begin
			case (state_r)
				EKQ_IDLE: begin
					col_r    <= 4'h0;
					settle_r <= 3'h0;
					if (any_row) begin
						state_r <= EKQ_DRIVE;
					end
				end
				EKQ_DRIVE: begin
					if (!col_sel_r[col_r] || settle_r == 3'(COL_SETTLE_CYC - 1)) begin
						cur_r    <= cur_nxt;
						settle_r <= 3'h0;
						if (col_r == 4'(NUM_COLS - 1)) begin
							col_r   <= 4'h0;
							key_r   <= 7'h00;
							state_r <= EKQ_EMIT;
						end else begin
							col_r <= col_r + 4'h1;
						end
					end else begin
						settle_r <= settle_r + 3'h1;
					end
				end
				EKQ_EMIT: begin
					// a full buffer holds the scan on this key
					if (!key_evt || sk_in_ready) begin
						if (key_evt) held_r[key_r] <= key_press;
						if (key_r == 7'(NUM_KEYS - 1)) begin
							state_r <= EKQ_CHECK;
						end else begin
							key_r <= key_r + 7'h01;
						end
					end
				end
				EKQ_CHECK: begin
					prev_r <= cur_r;
					if (held_r == '0 && cur_r == '0) begin
						state_r <= EKQ_IDLE;
					end else begin
						state_r <= EKQ_WAIT;
					end
				end
				EKQ_WAIT: begin
					if (tick) begin
						state_r <= EKQ_DRIVE;
					end
				end
				default: begin
					state_r <= EKQ_IDLE;
				end
			endcase
		end
	end

	// scan period timer, held at zero in idle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_r <= '0;
		end else if (state_r == EKQ_IDLE || tick) begin
			timer_r <= '0;
		end else begin
			timer_r <= timer_r + TW'(1);
		end
	end

	// queue storage, written at the tail, overwrites oldest when wrapping
	always_ff @(posedge clk) begin
		if (q_write) begin
			fifo_r[wp_r] <= sk_out_data;
		end
	end

	// queue pointers and pending event count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r  <= 4'h0;
			rp_r  <= 4'h0;
			cnt_r <= 4'h0;
		end else if (q_write) begin
			wp_r <= ptr_inc(wp_r);
			if (q_full) begin
				rp_r <= ptr_inc(rp_r);
			end else begin
				cnt_r <= cnt_r + 4'h1;
			end
		end else if (q_pop) begin
			rp_r  <= ptr_inc(rp_r);
			cnt_r <= cnt_r - 4'h1;
		end
	end

	// write strobes for configuration
	wire wr_cfg  = reg_wr & (reg_addr == ADDR_CFG);
	wire wr_stat = reg_wr & (reg_addr == ADDR_INT_STAT);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r     <= CFG_RST;
			row_sel_r <= NUM_ROWS'(SEL_RST);
			col_sel_r <= NUM_COLS'(SEL_RST);
		end else if (reg_wr) begin
			if (wr_cfg) cfg_r <= reg_wdata;
			if (reg_addr == ADDR_SEL_ROW) row_sel_r <= reg_wdata;
			if (reg_addr == ADDR_SEL_COL_LO) col_sel_r[7:0] <= reg_wdata;
			if (reg_addr == ADDR_SEL_COL_HI) col_sel_r[9:8] <= reg_wdata[1:0];
		end
	end

	// sticky flags: hardware set wins over a write-one clear
	wire ke_set    = q_write & ~q_full & cfg_r[CFG_KEY_EVENT_IRQ_ENABLE_BIT];
	wire ke_clr    = wr_stat & reg_wdata[STAT_KE_BIT] & q_empty;
	wire ovf_set   = q_ovf;
	wire ovf_clr   = wr_stat & reg_wdata[STAT_OVF_BIT];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ke_flag_r  <= 1'b0;
			ovf_flag_r <= 1'b0;
		end else begin
			ke_flag_r  <= ke_set | (ke_flag_r & ~ke_clr);
			ovf_flag_r <= ovf_set | (ovf_flag_r & ~ovf_clr);
		end
	end

	// interrupt pin pulls low while an enabled flag stands
	wire irq = (ke_flag_r & cfg_r[CFG_KEY_EVENT_IRQ_ENABLE_BIT])
		| (ovf_flag_r & cfg_r[CFG_OVF_IEN_BIT]);
	assign int_out = 1'b0;
	assign int_oe  = irq;

	// read data mux; an empty queue answers zero
	wire [7:0] evt_rdata  = q_empty ? 8'h00 : fifo_r[rp_r];
	wire [7:0] stat_rdata = {6'h00, ovf_flag_r, ke_flag_r};
	wire [7:0] rd_mux =
		is_evt_addr(reg_addr)          ? evt_rdata :
		(reg_addr == ADDR_CFG)         ? cfg_r :
		(reg_addr == ADDR_INT_STAT)    ? stat_rdata :
		(reg_addr == ADDR_EVT_CNT)     ? {4'h0, cnt_r} :
		(reg_addr == ADDR_SEL_ROW)     ? row_sel_r :
		(reg_addr == ADDR_SEL_COL_LO)  ? col_sel_r[7:0] :
		(reg_addr == ADDR_SEL_COL_HI)  ? {6'h00, col_sel_r[9:8]} :
		8'h00;

	// read data is registered so it survives the pop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 8'h00;
		end else if (reg_rd) begin
			rdata_r <= rd_mux;
		end
	end

	assign reg_rdata = rdata_r;

endmodule : ekq_keypad

// *** testbench/ekq_keypad_properties.sv ***
// port checker for the keypad scanner and event queue
// assumes one clock domain and the active-low async reset of the scanner
`timescale 1ns/1ps
module ekq_keypad_properties
	import ekq_pkg::*;
(
	// clock and reset
	input wire logic                         clk,
	input wire logic                         rst_n,
	// register port
	input wire logic [7:0]                   reg_addr,
	input wire logic                         reg_wr,
	input wire logic                         reg_rd,
	input wire logic [7:0]                   reg_rdata,
	// pins
	input wire logic [ekq_pkg::NUM_ROWS-1:0] row_pullup_en,
	input wire logic [ekq_pkg::NUM_COLS-1:0] col_out,
	input wire logic [ekq_pkg::NUM_COLS-1:0] col_oe,
	input wire logic [ekq_pkg::NUM_COLS-1:0] col_pullup_en,
	input wire logic                         int_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// reads of any of the ten event ports
	wire evt_rd = reg_rd && reg_addr >= ADDR_EVT_FIRST && reg_addr <= ADDR_EVT_LAST;

	property p_cols_selected; (col_oe & col_pullup_en) == '0; endproperty
	a_cols_selected: assert property (p_cols_selected) else $error("unselected column driven");
	property p_scan_one_col; $onehot0(col_oe) || col_oe == ~col_pullup_en; endproperty
	a_scan_one_col: assert property (p_scan_one_col) else $error("several columns in scan");
	property p_idle_levels; row_pullup_en == '1 && col_out == '0; endproperty
	a_idle_levels: assert property (p_idle_levels) else $error("row pull-up or drive level");
	property p_code_range;
		evt_rd |=> reg_rdata[6:0] <= 7'h50 && (reg_rdata[6:0] != 7'h00 || !reg_rdata[7]);
	endproperty
	a_code_range: assert property (p_code_range) else $error("bad event byte");
	property p_count_range; reg_rd && reg_addr == ADDR_EVT_CNT |=> reg_rdata <= 8'h0A; endproperty
	a_count_range: assert property (p_count_range) else $error("count above ten");
	// interrupt only drops after a host write to status or configuration
	property p_irq_hold;
		$fell(int_oe) |-> $past(reg_wr)
			&& ($past(reg_addr) == ADDR_INT_STAT || $past(reg_addr) == ADDR_CFG);
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped unasked");
	property p_rdata_stands; !reg_rd |=> $stable(reg_rdata); endproperty
	a_rdata_stands: assert property (p_rdata_stands) else $error("read data moved");
	// each scanned column is held for the six-cycle settle time
	property p_col_settle; $changed(col_oe) && $onehot(col_oe) |=> $stable(col_oe)[*5]; endproperty
	a_col_settle: assert property (p_col_settle) else $error("column settle too short");
endmodule : ekq_keypad_properties

bind ekq_keypad ekq_keypad_properties i_ekq_keypad_properties (
	.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .row_pullup_en(row_pullup_en), .col_out(col_out),
	.col_oe(col_oe), .col_pullup_en(col_pullup_en), .int_oe(int_oe)
);

// *** testbench/ekq_matrix_model.sv ***
// switch matrix seen from the scanner's pins
// assumes columns pull low when enabled and rows have pull-ups
`timescale 1ns/1ps
module ekq_matrix_model
	import ekq_pkg::*;
(
	// column drive from the scanner
	input  wire logic [ekq_pkg::NUM_COLS-1:0] col_oe,
	// closed switches, bit = row * ten + column
	input  wire logic [ekq_pkg::NUM_KEYS-1:0] key_closed,
	// rows back to the scanner
	output logic      [ekq_pkg::NUM_ROWS-1:0] row_in
);
	// a row falls only through a closed switch on a driven column, else the pull-up wins
	always_comb begin
		row_in = '1;
		for (int r = 0; r < NUM_ROWS; r++) begin
			for (int c = 0; c < NUM_COLS; c++) begin
				if (key_closed[r * NUM_COLS + c] && col_oe[c]) begin
					row_in[r] = 1'b0;
				end
			end
		end
	end
endmodule : ekq_matrix_model

// *** testbench/ekq_keypad_bench.sv ***
// self-checking bench for the keypad scanner and event queue
// assumes a short scan period so that each scan period takes only 200 cycles
`timescale 1ns/1ps
module ekq_keypad_bench;
	import ekq_pkg::*;
	localparam int PER = 200;
	logic                clk;
	logic                rst_n;
	logic                reg_wr;
	logic                reg_rd;
	logic                int_out;
	logic                int_oe;
	logic [7:0]          reg_addr;
	logic [7:0]          reg_wdata;
	logic [7:0]          reg_rdata;
	logic [NUM_ROWS-1:0] row_in;
	logic [NUM_ROWS-1:0] row_pullup_en;
	logic [NUM_COLS-1:0] col_out;
	logic [NUM_COLS-1:0] col_oe;
	logic [NUM_COLS-1:0] col_pullup_en;
	logic [NUM_KEYS-1:0] keys;
	int                  n_fail = 0;
	int                  checks_done = 0;
	int                  ks [6] = '{0, 9, 10, 33, 45, 79};

	ekq_keypad #(.SCAN_PERIOD_CYC(PER)) i_ekq_keypad (
		.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .row_in(row_in),
		.row_pullup_en(row_pullup_en), .col_out(col_out), .col_oe(col_oe),
		.col_pullup_en(col_pullup_en), .int_out(int_out), .int_oe(int_oe)
	);
	ekq_matrix_model i_ekq_matrix_model (.col_oe(col_oe), .key_closed(keys), .row_in(row_in));

	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic chk(input logic [9:0] seen, input logic [9:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic stop_test();
		if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	// one-cycle strobes, launched at the falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask : rd

	task automatic rc(input logic [7:0] a, input logic [7:0] exp, input string what);
		logic [7:0] d;
		rd(a, d);
		chk({2'b00, d}, {2'b00, exp}, what);
	endtask : rc

	// polls the event count; a debounce never needs more than a few periods
	task automatic wait_cnt(input logic [7:0] n);
		logic [7:0] d;
		int i;
		for (i = 0; i < 100; i++) begin
			rd(ADDR_EVT_CNT, d);
			if (d === n) break;
			repeat (20) @(negedge clk);
		end
		if (i == 100) begin
			n_fail++;
			stop_test();
		end
	endtask : wait_cnt

	initial begin
		rst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		keys = '0;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		chk(col_oe, 10'h000, "col_oe reset");
		chk(col_pullup_en, 10'h3FF, "col pull-ups reset");
		chk(10'(int_out), 10'h000, "int drive level");
		rc(ADDR_CFG, CFG_RST, "cfg reset");
		rc(ADDR_SEL_ROW, SEL_RST, "row select reset");
		rc(ADDR_EVT_FIRST, 8'h00, "empty queue");
		rc(8'h30, 8'h00, "unmapped");
		wr(ADDR_SEL_ROW, 8'hFF);
		wr(ADDR_SEL_COL_LO, 8'hFF);
		wr(ADDR_SEL_COL_HI, 8'h03);
		wr(ADDR_CFG, 8'h01);
		rc(ADDR_SEL_COL_HI, 8'h03, "column select");
		chk(col_oe, 10'h3FF, "idle columns");
		// closure shorter than one period leaves no event
		keys[23] = 1'b1;
		repeat (40) @(negedge clk);
		keys[23] = 1'b0;
		repeat (3 * PER) @(negedge clk);
		rc(ADDR_EVT_CNT, 8'h00, "glitch");
		// row 2 column 3 press and release
		keys[23] = 1'b1;
		wait_cnt(8'h01);
		chk(10'(int_oe), 10'h001, "irq");
		keys[23] = 1'b0;
		wait_cnt(8'h02);
		wr(ADDR_INT_STAT, 8'h01);
		rc(ADDR_INT_STAT, 8'h01, "clear refused");
		rc(ADDR_EVT_FIRST, {1'b1, 7'(2 * NUM_COLS + 3 + 1)}, "press");
		rc(ADDR_EVT_LAST, {1'b0, 7'(2 * NUM_COLS + 3 + 1)}, "release");
		rc(ADDR_EVT_CNT, 8'h00, "drained");
		rc(8'h08, 8'h00, "read past end");
		wr(ADDR_INT_STAT, 8'h01);
		rc(ADDR_INT_STAT, 8'h00, "flag cleared");
		chk(10'(int_oe), 10'h000, "irq off");
		// column 3 left out: a key on column 2 must not echo onto it
		wr(ADDR_SEL_COL_LO, 8'hF7);
		keys[22] = 1'b1;
		wait_cnt(8'h01);
		keys[22] = 1'b0;
		wait_cnt(8'h02);
		repeat (2 * PER) @(negedge clk);
		rc(ADDR_EVT_CNT, 8'h02, "skipped column");
		rc(ADDR_EVT_FIRST, {1'b1, 7'(2 * NUM_COLS + 2 + 1)}, "press col 2");
		rc(ADDR_EVT_FIRST, {1'b0, 7'(2 * NUM_COLS + 2 + 1)}, "release col 2");
		wr(ADDR_SEL_COL_LO, 8'hFF);
		// twelve events into a ten-deep queue, discard mode
		wr(ADDR_CFG, 8'h03);
		foreach (ks[k]) keys[ks[k]] = 1'b1;
		wait_cnt(8'h06);
		keys = '0;
		wait_cnt(8'h0A);
		repeat (2 * PER) @(negedge clk);
		rc(ADDR_INT_STAT, 8'h03, "overflow flag");
		chk(10'(int_oe), 10'h001, "overflow irq");
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			rc(ADDR_EVT_FIRST + 8'(i), {i < 6, 7'(ks[i % 6] + 1)}, "queue order");
		end
		rc(ADDR_EVT_CNT, 8'h00, "count empty");
		// same twelve events in wrap mode: the two oldest are overwritten
		wr(ADDR_INT_STAT, 8'h03);
		rc(ADDR_INT_STAT, 8'h00, "flags cleared");
		chk(10'(int_oe), 10'h000, "irq released");
		wr(ADDR_CFG, 8'h23);
		foreach (ks[k]) keys[ks[k]] = 1'b1;
		wait_cnt(8'h06);
		keys = '0;
		wait_cnt(8'h0A);
		repeat (2 * PER) @(negedge clk);
		rc(ADDR_INT_STAT, 8'h03, "wrap overflow flag");
		rc(ADDR_EVT_CNT, 8'h0A, "wrap count");
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			rc(ADDR_EVT_FIRST + 8'(i), {i < 4, 7'(ks[(i + 2) % 6] + 1)}, "wrap order");
		end
		stop_test();
	end
endmodule : ekq_keypad_bench
